// File: hdl/sar_adc_pkg.sv
// Constants, types and helpers for the converter sequencer
//
// Contract
// - 10-bit successive-approximation results; single and scan modes only.
// - Single mode converts the selected channel once when the start flag sets.
// - Single-mode result goes to the converted channel's own result register.
// - Single-mode end sets end flag; interrupt raised when enable is set.
// - Start flag reads 1 during single conversion, hardware clears it at end.
// - Clearing start mid-conversion abandons it and returns to wait.
// - Scan-enable/size 10 gives groups up to four, 11 up to eight.
// - Four-channel groups start at input 0, 4, 8 or 12 by channel bits 3:2.
// - Eight-channel groups start at input 0 or 8 by channel bit 3.
// - Scan stores each result in its channel's register as it finishes.
// - Scan sets end flag and interrupt only after the whole group.
// - After a full group, conversion restarts at the group's first channel.
// - Hardware never clears start flag in scan; groups repeat while it is 1.
// - Clearing start stops a scan to wait; next start begins at first channel.
// - After start: start delay, then sample-and-hold window, then conversion.
// - Delay 18-33/10-17/6-9/4-5, sample 127/63/31/15 states per clock select.
// - First or single conversion takes 515-530/259-266/131-134/67-68 states.
// - Later scan conversions take fixed 512/256/128/64 states.
// - Trigger select 11: falling edge on external pin sets the start flag.
// - Triggered conversions behave exactly as software-started ones.
// - Scan start from software, timer trigger or pin begins at first channel.
// - The conversion end interrupt can serve as a DMA start request.
// - Single mode codes 0000-0111 select inputs 0-7; top bit set prohibited.
// - Trigger select 01 enables timer trigger, 00 disables, 10 prohibited.
// - End flag cleared only by writing 0; writing 1 leaves it.
// - Scan-enable 0 selects single mode whatever the scan-size bit.
package sar_adc_pkg;

    localparam int RES_W = 10;
    localparam int NUM_CH = 16;
    localparam int CNT_W = 10;

    // Register byte offsets
    localparam logic [7:0] OFF_CSR = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [1:0] RES_BASE_HI = 2'h1;

    // Control/status field positions
    localparam int CSR_END_BIT = 7;
    localparam int CSR_IEN_BIT = 6;
    localparam int CSR_START_BIT = 5;
    localparam int CSR_CH_LSB = 0;

    // Control field positions
    localparam int CTRL_TRIG_LSB = 6;
    localparam int CTRL_SCAN_ENABLE_BIT_BIT = 5;
    localparam int CTRL_SCAN_SIZE_BIT_BIT = 4;
    localparam int CTRL_CKS_LSB = 2;

    localparam logic [1:0] TRIG_OFF = 2'h0;
    localparam logic [1:0] TRIG_TIMER = 2'h1;
    localparam logic [1:0] TRIG_EXT = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One state is one clock period
    localparam int CLK_PERIOD_NS = 10;
    localparam int STATE_NS = 10;
    localparam int STATE_CYC = STATE_NS / CLK_PERIOD_NS;

    localparam logic [RES_W-1:0] SAR_MSB = 10'h200;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONV = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic sample;
        logic [3:0] chan;
        logic [RES_W-1:0] dac;
    } sar_drive_t;

    // Fixed conversion length in cycles
    function automatic logic [CNT_W-1:0] conv_cycles(input logic [1:0] cks);
        int s;
        case (cks)
            2'h0: s = 512;
            2'h1: s = 256;
            2'h2: s = 128;
            default: s = 64;
        endcase
        return CNT_W'(s * STATE_CYC);
    endfunction

    // Least start delay in cycles
    function automatic logic [CNT_W-1:0] delay_cycles(input logic [1:0] cks);
        int s;
        case (cks)
            2'h0: s = 18;
            2'h1: s = 10;
            2'h2: s = 6;
            default: s = 4;
        endcase
        return CNT_W'(s * STATE_CYC);
    endfunction

    // Sampling window in cycles
    function automatic logic [CNT_W-1:0] sample_cycles(input logic [1:0] cks);
        int s;
        case (cks)
            2'h0: s = 127;
            2'h1: s = 63;
            2'h2: s = 31;
            default: s = 15;
        endcase
        return CNT_W'(s * STATE_CYC);
    endfunction

    // Cycles per bit decision, remainder of the window over ten bits
    function automatic logic [CNT_W-1:0] bit_cycles(input logic [1:0] cks);
        return CNT_W'((int'(conv_cycles(cks)) - int'(sample_cycles(cks)))
            / RES_W);
    endfunction

endpackage

// File: hdl/sar_adc_seq.sv
// Successive-approximation converter sequencer with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module sar_adc_seq #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // AXI4-Lite write address and data
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Triggers
    input wire logic timer_trig,
    input wire logic ext_trigger_pin_n,
    // Analog front end
    input wire logic comp_in,
    output sar_adc_pkg::sar_drive_t drive,
    // Conversion end request
    output logic conv_end_irq,
    output logic dma_req
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;

    logic end_r, ien_r, start_r;
    logic [3:0] chsel_r;
    logic [1:0] trig_r, cks_r;
    logic scan_enable_bit_r, scan_size_bit_r;
    logic end_nxt, start_nxt;

    logic ext_meta_r, ext_sync_r, ext_prev_r;
    logic comp_meta_r, comp_sync_r;

    sar_adc_pkg::seq_state_t st_r, st_nxt;
    logic [sar_adc_pkg::CNT_W-1:0] cnt_r, cnt_nxt, tmr_r, tmr_nxt;
    logic [3:0] ch_r, ch_nxt;
    logic [sar_adc_pkg::RES_W-1:0] sar_r, sar_nxt, mask_r, mask_nxt;
    logic conv_done, group_done;

    logic [sar_adc_pkg::RES_W-1:0] res_r [sar_adc_pkg::NUM_CH];
    sar_adc_pkg::sar_drive_t drive_r;
    logic irq_r, dma_r;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    wire aw_take = s_axi_awvalid & s_axi_wvalid & ~awready_r & ~bvalid_r;
    wire wr_hs = s_axi_awvalid & awready_r & s_axi_wvalid & wready_r;
    wire wr_lane = s_axi_wstrb[0];
    wire wa_csr = s_axi_awaddr[7:0] == sar_adc_pkg::OFF_CSR;
    wire wa_ctrl = s_axi_awaddr[7:0] == sar_adc_pkg::OFF_CTRL;
    wire wa_res = s_axi_awaddr[7:6] == sar_adc_pkg::RES_BASE_HI
        && s_axi_awaddr[1:0] == 2'h0;
    wire wr_csr = wr_hs & wa_csr & wr_lane;
    wire wr_ctrl = wr_hs & wa_ctrl & wr_lane;
    wire [1:0] wr_resp = (wa_csr | wa_ctrl | wa_res) ?
        sar_adc_pkg::RESP_OKAY : sar_adc_pkg::RESP_SLVERR;

    wire ar_take = s_axi_arvalid & ~arready_r & ~rvalid_r;
    wire rd_hs = s_axi_arvalid & arready_r;
    wire ra_csr = s_axi_araddr[7:0] == sar_adc_pkg::OFF_CSR;
    wire ra_ctrl = s_axi_araddr[7:0] == sar_adc_pkg::OFF_CTRL;
    wire ra_res = s_axi_araddr[7:6] == sar_adc_pkg::RES_BASE_HI
        && s_axi_araddr[1:0] == 2'h0;
    wire [3:0] ra_idx = s_axi_araddr[5:2];

    wire [31:0] csr_word = {24'h000000, end_r, ien_r, start_r, 1'b0,
        chsel_r};
    wire [31:0] ctrl_word = {24'h000000, trig_r, scan_enable_bit_r, scan_size_bit_r, cks_r,
        2'b00};
    wire [31:0] res_word = {22'h000000, res_r[ra_idx]};
    wire [31:0] rd_mux = ra_csr ? csr_word :
        ra_ctrl ? ctrl_word :
        ra_res ? res_word : 32'h00000000;
    wire [1:0] rd_resp = (ra_csr | ra_ctrl | ra_res) ?
        sar_adc_pkg::RESP_OKAY : sar_adc_pkg::RESP_SLVERR;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake

    always_ff @(posedge core_clk) begin
        if (rst) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= sar_adc_pkg::RESP_OKAY;
        end else begin
            awready_r <= aw_take;
            wready_r <= aw_take;
            if (wr_hs) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_resp;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= sar_adc_pkg::RESP_OKAY;
        end else begin
            arready_r <= ar_take;
            if (rd_hs) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_mux;
                rresp_r <= rd_resp;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger and comparator synchronisers

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ext_meta_r <= 1'b1;
            ext_sync_r <= 1'b1;
            ext_prev_r <= 1'b1;
            comp_meta_r <= 1'b0;
            comp_sync_r <= 1'b0;
        end else begin
            ext_meta_r <= ext_trigger_pin_n;
            ext_sync_r <= ext_meta_r;
            ext_prev_r <= ext_sync_r;
            comp_meta_r <= comp_in;
            comp_sync_r <= comp_meta_r;
        end
    end

    wire ext_fall = ext_prev_r & ~ext_sync_r;
    // Prohibited trigger code 10 starts nothing
    wire hw_trig = (trig_r == sar_adc_pkg::TRIG_TIMER & timer_trig)
        | (trig_r == sar_adc_pkg::TRIG_EXT & ext_fall);

    ////////////////////////////////////////////////////////////////////////
    // Channel group

    wire scan_mode = scan_enable_bit_r;
    // Top channel bit is ignored in single mode, so code 1xxx stays in 0-7
    wire [3:0] ch_first = !scan_mode ? {1'b0, chsel_r[2:0]} :
        !scan_size_bit_r ? {chsel_r[3:2], 2'b00} :
        {chsel_r[3], 3'b000};
    // Group end is the selected code itself for both group sizes
    wire [3:0] ch_last = scan_mode ? chsel_r : ch_first;

    wire [sar_adc_pkg::CNT_W-1:0] n_conv = sar_adc_pkg::conv_cycles(cks_r);
    wire [sar_adc_pkg::CNT_W-1:0] n_delay = sar_adc_pkg::delay_cycles(cks_r);
    wire [sar_adc_pkg::CNT_W-1:0] n_spl = sar_adc_pkg::sample_cycles(cks_r);
    wire [sar_adc_pkg::CNT_W-1:0] n_bit = sar_adc_pkg::bit_cycles(cks_r);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r + 1'b1;
        ch_nxt = ch_r;
        sar_nxt = sar_r;
        mask_nxt = mask_r;
        tmr_nxt = tmr_r;
        conv_done = 1'b0;
        group_done = 1'b0;
        case (st_r)
            sar_adc_pkg::ST_IDLE: begin
                cnt_nxt = '0;
                if (start_r) begin
                    st_nxt = sar_adc_pkg::ST_DELAY;
                    ch_nxt = ch_first;
                end
            end
            sar_adc_pkg::ST_DELAY: begin
                if (!start_r) begin
                    st_nxt = sar_adc_pkg::ST_IDLE;
                end else if (cnt_r == n_delay - 2'd2) begin
                    // Idle cycle plus this wait make up the start delay
                    st_nxt = sar_adc_pkg::ST_CONV;
                    cnt_nxt = '0;
                end
            end
            sar_adc_pkg::ST_CONV: begin
                if (!start_r) begin
                    st_nxt = sar_adc_pkg::ST_IDLE;
                    cnt_nxt = '0;
                end else begin
                    if (cnt_r == n_spl - 1'b1) begin
                        sar_nxt = sar_adc_pkg::SAR_MSB;
                        mask_nxt = sar_adc_pkg::SAR_MSB;
                        tmr_nxt = '0;
                    end else if (mask_r != '0) begin
                        if (tmr_r == n_bit - 1'b1) begin
                            // Comparator high keeps the trial bit
                            sar_nxt = (comp_sync_r ? sar_r : sar_r & ~mask_r)
                                | (mask_r >> 1);
                            mask_nxt = mask_r >> 1;
                            tmr_nxt = '0;
                        end else begin
                            tmr_nxt = tmr_r + 1'b1;
                        end
                    end
                    if (cnt_r == n_conv - 1'b1) begin
                        conv_done = 1'b1;
                        cnt_nxt = '0;
                        if (!scan_mode) begin
                            group_done = 1'b1;
                            st_nxt = sar_adc_pkg::ST_IDLE;
                        end else if (ch_r == ch_last) begin
                            group_done = 1'b1;
                            ch_nxt = ch_first;
                        end else begin
                            ch_nxt = ch_r + 1'b1;
                        end
                    end
                end
            end
            default: begin
                st_nxt = sar_adc_pkg::ST_IDLE;
                cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= sar_adc_pkg::ST_IDLE;
            cnt_r <= '0;
            tmr_r <= '0;
            ch_r <= 4'h0;
            sar_r <= '0;
            mask_r <= '0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            tmr_r <= tmr_nxt;
            ch_r <= ch_nxt;
            sar_r <= sar_nxt;
            mask_r <= mask_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and status bits

    // Hardware set wins over a software clear in the same cycle
    always_comb begin
        start_nxt = start_r;
        if (conv_done && !scan_mode) begin
            start_nxt = 1'b0;
        end
        if (wr_csr) begin
            start_nxt = s_axi_wdata[sar_adc_pkg::CSR_START_BIT];
        end
        if (hw_trig) begin
            start_nxt = 1'b1;
        end
        end_nxt = end_r;
        if (wr_csr && !s_axi_wdata[sar_adc_pkg::CSR_END_BIT]) begin
            end_nxt = 1'b0;
        end
        if (group_done) begin
            end_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            start_r <= 1'b0;
            end_r <= 1'b0;
            ien_r <= 1'b0;
            chsel_r <= 4'h0;
        end else begin
            start_r <= start_nxt;
            end_r <= end_nxt;
            if (wr_csr) begin
                ien_r <= s_axi_wdata[sar_adc_pkg::CSR_IEN_BIT];
                chsel_r <= s_axi_wdata[sar_adc_pkg::CSR_CH_LSB +: 4];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            trig_r <= sar_adc_pkg::TRIG_OFF;
            scan_enable_bit_r <= 1'b0;
            scan_size_bit_r <= 1'b0;
            cks_r <= 2'h0;
        end else if (wr_ctrl) begin
            trig_r <= s_axi_wdata[sar_adc_pkg::CTRL_TRIG_LSB +: 2];
            scan_enable_bit_r <= s_axi_wdata[sar_adc_pkg::CTRL_SCAN_ENABLE_BIT_BIT];
            scan_size_bit_r <= s_axi_wdata[sar_adc_pkg::CTRL_SCAN_SIZE_BIT_BIT];
            cks_r <= s_axi_wdata[sar_adc_pkg::CTRL_CKS_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result registers

    for (genvar i = 0; i < sar_adc_pkg::NUM_CH; i++) begin : g_res
        always_ff @(posedge core_clk) begin
            if (rst) begin
                res_r[i] <= '0;
            end else if (conv_done && ch_r == 4'(i)) begin
                res_r[i] <= sar_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    always_ff @(posedge core_clk) begin
        if (rst) begin
            drive_r <= '0;
            irq_r <= 1'b0;
            dma_r <= 1'b0;
        end else begin
            drive_r.sample <= st_nxt == sar_adc_pkg::ST_CONV
                && cnt_nxt < n_spl;
            drive_r.chan <= ch_nxt;
            drive_r.dac <= sar_nxt;
            // Level request, drops once flag or enable clears
            irq_r <= end_nxt & ien_r;
            // One pulse per finished group while interrupts are enabled, for the DMA controller
            dma_r <= group_done & ien_r;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign drive = drive_r;
    assign conv_end_irq = irq_r;
    assign dma_req = dma_r;

endmodule
`default_nettype wire

// File: sim/analog_front_model.sv
// Comparator model standing in for the analog inputs
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
    // Converter side
    input wire sar_adc_pkg::sar_drive_t drive,
    output logic comp_in,
    // Level pattern
    input wire logic [9:0] seed
);
    logic [9:0] level;
    // Each input holds a fixed level of its own
    assign level = seed + {drive.chan, 6'h00} + {6'h00, drive.chan};
    assign comp_in = (level >= drive.dac);
endmodule
`default_nettype wire

// File: sim/sar_adc_seq_monitor.sv
// Port checker for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_adc_seq_monitor (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Converter side
    input wire sar_adc_pkg::sar_drive_t drive,
    input wire logic conv_end_irq,
    input wire logic dma_req
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [9:0] run_r;
    always_ff @(posedge core_clk) begin
        run_r <= (rst || !drive.sample) ? 10'h000 : run_r + 10'h001;
    end
    property p_aw_take;
        s_axi_awready |-> s_axi_wready && s_axi_awvalid && s_axi_wvalid;
    endproperty
    a_aw_take: assert property (p_aw_take) else $error("write taken alone");
    property p_b_after;
        $rose(s_axi_bvalid) |-> $past(s_axi_awready);
    endproperty
    a_b_after: assert property (p_b_after) else $error("bvalid early");
    property p_b_hold;
        s_axi_bvalid |=> s_axi_bvalid != $past(s_axi_bready);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_after;
        $rose(s_axi_rvalid) |-> $past(s_axi_arready);
    endproperty
    a_r_after: assert property (p_r_after) else $error("rvalid early");
    property p_r_hold;
        s_axi_rvalid |=> s_axi_rvalid != $past(s_axi_rready);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
    property p_sample_len;
        $fell(drive.sample) |->
            run_r inside {10'h07F, 10'h03F, 10'h01F, 10'h00F};
    endproperty
    a_sample_len: assert property (p_sample_len)
        else $error("bad window");
    property p_chan_hold;
        drive.sample && $past(drive.sample) |-> $stable(drive.chan);
    endproperty
    a_chan_hold: assert property (p_chan_hold)
        else $error("chan moved");
    property p_dac_msb;
        $fell(drive.sample) |-> ##[0:2] (drive.dac == sar_adc_pkg::SAR_MSB);
    endproperty
    a_dac_msb: assert property (p_dac_msb) else $error("no msb trial");
    property p_dma_pulse;
        dma_req |=> !dma_req;
    endproperty
    a_dma_pulse: assert property (p_dma_pulse)
        else $error("dma too long");
    property p_dma_irq;
        dma_req |-> ##[0:2] conv_end_irq;
    endproperty
    a_dma_irq: assert property (p_dma_irq)
        else $error("no irq at end");
    property p_irq_drop;
        $fell(conv_end_irq) |->
            $past(s_axi_wvalid) || $past(s_axi_wvalid, 2);
    endproperty
    a_irq_drop: assert property (p_irq_drop)
        else $error("irq fell alone");
    c_dma: cover property (dma_req);
    c_sample: cover property ($fell(drive.sample));
    c_irq: cover property ($fell(conv_end_irq));
endmodule
bind sar_adc_seq sar_adc_seq_monitor mon (.core_clk(core_clk), .rst(rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .drive(drive),
    .conv_end_irq(conv_end_irq), .dma_req(dma_req));
`default_nettype wire

// File: sim/sar_adc_seq_bench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_adc_seq_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, timer_trig = 1'b0;
    logic ext_trigger_pin_n = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, comp_in, conv_end_irq, dma_req;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, br, tr;
    logic [31:0] s_axi_rdata, d;
    sar_adc_pkg::sar_drive_t drive;
    logic [9:0] seed;
    logic [3:0] ch, first;
    int failures = 0, checked = 0, cycles = 0, n, cnt;
    always #5 core_clk = ~core_clk;
    sar_adc_seq DUT (.core_clk(core_clk), .rst(rst),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .timer_trig(timer_trig),
        .ext_trigger_pin_n(ext_trigger_pin_n), .comp_in(comp_in),
        .drive(drive), .conv_end_irq(conv_end_irq), .dma_req(dma_req));
    analog_front_model front (.drive(drive), .comp_in(comp_in), .seed(seed));
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        do begin
            @(posedge core_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge core_clk);
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        s_axi_araddr <= a;
        do begin
            @(posedge core_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic wait_dma(input int lim);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (dma_req !== 1'b1 && n < lim);
    endtask
    function automatic logic [31:0] lvl(input logic [3:0] c);
        return {22'h0, seed + {c, 6'h00} + {6'h00, c}};
    endfunction
    // Columns: least total, most total, later scan conversion
    function automatic int span(input logic [1:0] k, input int col);
        int t [3][4] = '{'{515, 259, 131, 67}, '{530, 266, 134, 68},
            '{512, 256, 128, 64}};
        return t[col][k];
    endfunction
    // A hang ends the run as a mismatch
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 10'($urandom(85682));
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        axi_rd(8'h00);
        chk(d, 32'h0);
        axi_rd(8'h04);
        chk(d, 32'h0);
        axi_rd(8'h20);
        chk({30'h0, r}, 32'h2);
        axi_wr(8'h24, 32'h0);
        chk({30'h0, br}, 32'h2);
        for (int k = 0; k < 4; k++) begin
            ch = 4'($urandom_range(7));
            axi_wr(8'h04, {28'h0, 2'(k), 2'h0});
            axi_wr(8'h00, {24'h0, 8'h60 | ch});
            wait_dma(1000);
            chk(n >= span(2'(k), 0) - 4
                && n <= span(2'(k), 1) + 2, 1);
            axi_rd(8'h00);
            chk(d, {24'h0, 8'hC0 | ch});
            chk(conv_end_irq, 1);
            axi_rd(8'h40 + {2'h0, ch, 2'h0});
            chk(d, lvl(ch));
            axi_wr(8'h00, {24'h0, 8'hC0 | ch});
            chk(conv_end_irq, 1);
            axi_wr(8'h00, 32'h40);
            chk(conv_end_irq, 0);
        end
        // Abort after sampling, well inside the conversion
        axi_wr(8'h04, 32'h0C);
        axi_wr(8'h00, 32'h63);
        repeat (40) @(posedge core_clk);
        axi_wr(8'h00, 32'h43);
        repeat (100) @(posedge core_clk);
        axi_rd(8'h00);
        chk(d, 32'h43);
        for (int g = 0; g < 2; g++) begin
            ch = g ? 4'h9 : 4'h6;
            first = g ? 4'h8 : 4'h4;
            cnt = g ? 2 : 3;
            axi_wr(8'h04, g ? 32'h3C : 32'h2C);
            axi_wr(8'h00, {24'h0, 8'h60 | ch});
            n = 0;
            while (drive.sample !== 1'b1 && n < 100) begin
                @(posedge core_clk);
                n++;
            end
            chk(n < 100, 1);
            chk(drive.chan, first);
            wait_dma(1000);
            wait_dma(1000);
            chk(n, cnt * 64);
            axi_rd(8'h00);
            chk(d[5], 1);
            // Clear between sampling windows so no window is cut
            repeat (25) @(posedge core_clk);
            axi_wr(8'h00, {24'h0, 8'h40 | ch});
            for (int i = 0; i < cnt; i++) begin
                axi_rd(8'h40 + {2'h0, first + 4'(i), 2'h0});
                chk(d, lvl(first + 4'(i)));
            end
            axi_rd(8'h00);
            chk(d, {24'h0, 8'h40 | ch});
        end
        // Pin, prohibited, timer and off trigger selects
        for (int t = 0; t < 4; t++) begin
            tr = 2'(3 - t);
            ch = 4'($urandom_range(7));
            axi_wr(8'h04, {24'h0, tr, 6'h1C});
            axi_wr(8'h00, {24'h0, 8'h40 | ch});
            @(posedge core_clk);
            ext_trigger_pin_n <= 1'b0;
            timer_trig <= 1'b1;
            @(posedge core_clk);
            timer_trig <= 1'b0;
            wait_dma(300);
            chk(n <= 80, tr[0]);
            ext_trigger_pin_n <= 1'b1;
            axi_rd(8'h40 + {2'h0, ch, 2'h0});
            if (tr[0]) chk(d, lvl(ch));
            axi_wr(8'h00, 32'h40);
        end
        end_sim();
    end
endmodule
`default_nettype wire
